// *** design/edadp_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - nonpage external cycle is four clocks; internal cycle is one clock
// - stretch 1 adds one setup, two strobe, one hold clock
// - stretch 2 and 3 add each whole stretch cycle to strobe only
// - page select 10b: four clocks on hit, eight on miss
// - page select 01b: two clocks on hit, four on miss
// - upper byte equal to code page byte is a hit, no miss clocks
// - page select 00b always misses; stretch 1 totals seven clocks
// - stretch 4 adds two setup, one strobe, one hold stretch cycle
// - stretch 5 to 7 lengthen only the strobe
// - page select 11b takes four clocks, data and upper byte on port 2
// - register-indirect address is port 2 latch over working register
// - pointer-indirect address is the full active 16-bit pointer
// - first pointer at 82h/83h, second pointer at 84h/85h
// - control bit 0 selects the pointer all pointer operations use
// - bits 6 and 7 choose increment or decrement per pointer
// - auto-toggle bit 5 inverts select after qualifying operations
// - auto-step bit 4 steps active pointer after qualifying moves
// - auto-step on table read and pointer moves; toggle also step, load
module edadp_ctrl (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire edadp_pkg::edadp_sfr_req_t sfr_req,
  output logic [7:0]                     sfr_rdata,
  input  wire edadp_pkg::edadp_op_req_t  op_req,
  output logic                           op_ready,
  output logic                           op_done,
  output logic [7:0]                     xdata_rd,
  output logic [15:0]                    code_addr,
  input  wire logic                      page_enable,
  input  wire logic [1:0]                page_select,
  input  wire logic [2:0]                stretch_select,
  input  wire logic [7:0]                code_page_msb,
  input  wire logic [7:0]                p0_in,
  input  wire logic [7:0]                p2_in,
  output var edadp_pkg::edadp_pins_t     pins
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } edadp_state_t;

  // extra strobe clocks: two for the first stretch cycle, four per further one
  function automatic logic [5:0] edadp_xstrobe(input logic [2:0] s);
    return (s == 3'h0) ? 6'h00 : edadp_pkg::XSTROBE_1ST + {1'b0, s - 3'h1, 2'b00};
  endfunction

  // extra setup or hold clocks: lo for stretch 1 to 3, hi from stretch 4
  function automatic logic [5:0] edadp_xedge(input logic [2:0] s, input logic [5:0] lo,
                                             input logic [5:0] hi);
    return (s >= edadp_pkg::STRETCH_HI) ? hi : (s != 3'h0) ? lo : 6'h00;
  endfunction

  function automatic logic [15:0] edadp_step(input logic [15:0] p,
                                             input logic        down);
    return down ? p - 16'h0001 : p + 16'h0001;
  endfunction

  edadp_state_t state_r, state_nxt;
  logic [5:0]   cnt_r, cnt_nxt;
  logic [5:0]   es_r, ew_r, eh_r;
  logic [5:0]   es_nxt, ew_nxt, eh_nxt;
  logic [15:0]  ptr0_r, ptr1_r, ptr0_nxt, ptr1_nxt;
  logic [7:0]   ctrl_r, ctrl_nxt;
  logic [15:0]  addr_r, addr_nxt;
  logic [15:0]  load_r;
  logic [7:0]   wdata_r, wdata_nxt;
  logic         write_r, write_nxt;
  logic         mode2_r, mode2_nxt;
  edadp_pkg::edadp_op_t op_r;
  logic [7:0]   sfr_rdata_r;
  logic [7:0]   xdata_r;
  edadp_pkg::edadp_pins_t pins_nxt;

  // request decode and address choice
  wire       take    = op_ready & op_req.valid;
  wire       is_ptrx = (op_req.op == edadp_pkg::OP_XRD_PTR) |
                       (op_req.op == edadp_pkg::OP_XWR_PTR);
  wire       is_regx = (op_req.op == edadp_pkg::OP_XRD_REG) |
                       (op_req.op == edadp_pkg::OP_XWR_REG);
  wire       is_bus  = is_ptrx | is_regx;
  wire       sel     = ctrl_r[edadp_pkg::SEL_BIT];
  wire [15:0] act_ptr = sel ? ptr1_r : ptr0_r;
  wire [15:0] req_addr = is_ptrx ? act_ptr
                       : {op_req.p2_latch, op_req.reg_low};
  wire       req_wr  = (op_req.op == edadp_pkg::OP_XWR_PTR) |
                       (op_req.op == edadp_pkg::OP_XWR_REG);

  // page hit and miss-clock count
  wire       mode2    = page_enable & (page_select == edadp_pkg::PG_MODE2);
  wire       page_hit = (page_select != edadp_pkg::PG_ONE) &
                        (req_addr[15:8] == code_page_msb);
  wire [5:0] miss_len =
    !page_enable ? 6'h00 :
    (page_select == edadp_pkg::PG_ONE) ? edadp_pkg::MISS_ONE :
    (page_select == edadp_pkg::PG_TWO && !page_hit) ? edadp_pkg::MISS_TWO :
    (page_select == edadp_pkg::PG_FOUR && !page_hit) ? edadp_pkg::MISS_FOUR :
    6'h00;

  // base phase lengths per bus mode, nonpage and page mode 2 alike
  wire       pm_two = page_enable & (page_select == edadp_pkg::PG_TWO);
  wire       pm_one = page_enable & (page_select == edadp_pkg::PG_ONE);
  wire [5:0] b_setup  = pm_one ? edadp_pkg::SETUP_ONE
                      : pm_two ? edadp_pkg::SETUP_TWO : edadp_pkg::SETUP_STD;
  wire [5:0] b_strobe = pm_one ? edadp_pkg::STROBE_ONE
                      : pm_two ? edadp_pkg::STROBE_TWO : edadp_pkg::STROBE_STD;
  wire [5:0] b_hold   = pm_one ? edadp_pkg::HOLD_ONE
                      : pm_two ? edadp_pkg::HOLD_TWO : edadp_pkg::HOLD_STD;

  // stretch distribution over setup, strobe and hold
  wire [5:0] x_setup  = edadp_xedge(stretch_select, edadp_pkg::XSETUP_LO,
                                    edadp_pkg::XSETUP_HI);
  wire [5:0] x_strobe = edadp_xstrobe(stretch_select);
  wire [5:0] x_hold   = edadp_xedge(stretch_select, edadp_pkg::XHOLD_LO,
                                    edadp_pkg::XHOLD_HI);

  // phase end marks, frozen for the whole access
  wire [5:0] es_req = miss_len + b_setup + x_setup;
  wire [5:0] ew_req = es_req + b_strobe + x_strobe;
  wire [5:0] eh_req = ew_req + b_hold + x_hold;
  wire       take_bus = take & is_bus;
  assign es_nxt    = take_bus ? es_req : es_r;
  assign ew_nxt    = take_bus ? ew_req : ew_r;
  assign eh_nxt    = take_bus ? eh_req : eh_r;
  assign addr_nxt  = take ? (is_bus ? req_addr : act_ptr) : addr_r;
  assign wdata_nxt = take_bus ? op_req.wdata : wdata_r;
  assign write_nxt = take_bus ? req_wr : write_r;
  assign mode2_nxt = take_bus ? mode2 : mode2_r;

  // sequencer: bus moves run the counter, other operations take one clock
  wire last_busy = (cnt_r == eh_r - 6'h01);
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE:
      begin
        cnt_nxt = 6'h00;
        if (take)
          state_nxt = is_bus ? ST_BUSY : ST_DONE;
      end
      ST_BUSY:
      begin
        cnt_nxt = cnt_r + 6'h01;
        if (last_busy)
          state_nxt = ST_DONE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // pin drive for the coming cycle, from the next count
  wire busy_n   = (state_nxt == ST_BUSY);
  wire addr_ph  = (cnt_nxt < es_nxt);
  wire strobe_n = busy_n & ~addr_ph & (cnt_nxt < ew_nxt);
  always_comb
  begin
    pins_nxt.ale    = busy_n & addr_ph;
    pins_nxt.rd_n   = ~(strobe_n & ~write_nxt);
    pins_nxt.wr_n   = ~(strobe_n & write_nxt);
    pins_nxt.p0_out = (mode2_nxt | addr_ph) ? addr_nxt[7:0] : wdata_nxt;
    pins_nxt.p0_oe  = busy_n & (mode2_nxt | addr_ph | write_nxt);
    pins_nxt.p2_out = (mode2_nxt & ~addr_ph) ? wdata_nxt : addr_nxt[15:8];
    pins_nxt.p2_oe  = busy_n & (~mode2_nxt | addr_ph | write_nxt);
  end

  // read data is caught on the last strobe clock
  wire cap_rd = (state_r == ST_BUSY) & ~write_r & (cnt_r == ew_r - 6'h01);

  // pointer update when an operation finishes
  wire fin     = (state_r == ST_DONE);
  wire on_ptrx = (op_r == edadp_pkg::OP_XRD_PTR) | (op_r == edadp_pkg::OP_XWR_PTR);
  wire on_tab  = on_ptrx | (op_r == edadp_pkg::OP_CODE_RD);
  wire q_step  = fin & ((ctrl_r[edadp_pkg::STEP_BIT] & on_tab) |
                        (op_r == edadp_pkg::OP_STEP));
  wire q_tog   = fin & ctrl_r[edadp_pkg::TOG_BIT] &
                 (on_tab | (op_r == edadp_pkg::OP_STEP) |
                  (op_r == edadp_pkg::OP_LOAD));
  wire q_load  = fin & (op_r == edadp_pkg::OP_LOAD);
  wire act_dir = sel ? ctrl_r[edadp_pkg::DIR1_BIT] : ctrl_r[edadp_pkg::DIR0_BIT];
  wire [15:0] act_new = q_load ? load_r : edadp_step(act_ptr, act_dir);
  wire hw_upd  = q_step | q_load;

  // register writes; a hardware update wins over a write in the same clock
  wire w_p0l = sfr_req.wr & (sfr_req.addr == edadp_pkg::SFR_P0_LO);
  wire w_p0h = sfr_req.wr & (sfr_req.addr == edadp_pkg::SFR_P0_HI);
  wire w_p1l = sfr_req.wr & (sfr_req.addr == edadp_pkg::SFR_P1_LO);
  wire w_p1h = sfr_req.wr & (sfr_req.addr == edadp_pkg::SFR_P1_HI);
  wire w_ctl = sfr_req.wr & (sfr_req.addr == edadp_pkg::SFR_CTRL);
  always_comb
  begin
    ptr0_nxt = {w_p0h ? sfr_req.wdata : ptr0_r[15:8],
                w_p0l ? sfr_req.wdata : ptr0_r[7:0]};
    ptr1_nxt = {w_p1h ? sfr_req.wdata : ptr1_r[15:8],
                w_p1l ? sfr_req.wdata : ptr1_r[7:0]};
    if (hw_upd && !sel)
      ptr0_nxt = act_new;
    if (hw_upd && sel)
      ptr1_nxt = act_new;
    ctrl_nxt = w_ctl ? (sfr_req.wdata & edadp_pkg::CTRL_MASK) : ctrl_r;
    if (q_tog)
      ctrl_nxt[edadp_pkg::SEL_BIT] = ~sel;
  end

  // register read mux; unused control bits read as zero
  wire [7:0] rd_mux =
    (sfr_req.addr == edadp_pkg::SFR_P0_LO) ? ptr0_r[7:0] :
    (sfr_req.addr == edadp_pkg::SFR_P0_HI) ? ptr0_r[15:8] :
    (sfr_req.addr == edadp_pkg::SFR_P1_LO) ? ptr1_r[7:0] :
    (sfr_req.addr == edadp_pkg::SFR_P1_HI) ? ptr1_r[15:8] :
    (sfr_req.addr == edadp_pkg::SFR_CTRL)  ? ctrl_r : 8'h00;

  // sequencer and capture state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 6'h00;
      es_r    <= 6'h00;
      ew_r    <= 6'h00;
      eh_r    <= 6'h00;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
      write_r <= 1'b0;
      mode2_r <= 1'b0;
      op_r    <= edadp_pkg::OP_NONE;
      load_r  <= 16'h0000;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      es_r    <= es_nxt;
      ew_r    <= ew_nxt;
      eh_r    <= eh_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      write_r <= write_nxt;
      mode2_r <= mode2_nxt;
      if (take)
      begin
        op_r   <= op_req.op;
        load_r <= op_req.load_val;
      end
    end
  end

  // pointers, control and output registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ptr0_r      <= edadp_pkg::PTR_RST;
      ptr1_r      <= edadp_pkg::PTR_RST;
      ctrl_r      <= edadp_pkg::CTRL_RST;
      sfr_rdata_r <= 8'h00;
      xdata_r     <= 8'h00;
      pins        <= '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end
    else if (ce)
    begin
      ptr0_r <= ptr0_nxt;
      ptr1_r <= ptr1_nxt;
      ctrl_r <= ctrl_nxt;
      pins   <= pins_nxt;
      if (sfr_req.rd)
        sfr_rdata_r <= rd_mux;
      if (cap_rd)
        xdata_r <= mode2_r ? p2_in : p0_in;
    end
  end

  assign op_ready  = ce & (state_r == ST_IDLE);
  assign op_done   = ce & fin;
  assign sfr_rdata = sfr_rdata_r;
  assign xdata_rd  = xdata_r;
  assign code_addr = addr_r;

  // checking helpers: request snapshot, busy clocks, strobe width
  logic       pe_r, hit_r, strb_lo_r;
  logic [1:0] ps_r;
  logic [2:0] st_r;
  logic [5:0] bcyc_r, swid_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pe_r   <= 1'b0;
      hit_r  <= 1'b0;
      ps_r   <= 2'h0;
      st_r   <= 3'h0;
      bcyc_r <= 6'h00;
      swid_r <= 6'h00;
      strb_lo_r <= 1'b0;
    end
    else if (ce)
    begin
      if (take_bus)
      begin
        pe_r   <= page_enable;
        hit_r  <= page_hit;
        ps_r   <= page_select;
        st_r   <= stretch_select;
        bcyc_r <= 6'h00;
      end
      else if (state_r == ST_BUSY)
        bcyc_r <= bcyc_r + 6'h01;
      swid_r <= (!pins.rd_n || !pins.wr_n) ? swid_r + 6'h01 : 6'h00;
      strb_lo_r <= !pins.rd_n || !pins.wr_n;
    end
  end

  wire bus_fin = op_done & (on_ptrx | (op_r == edadp_pkg::OP_XRD_REG) |
                            (op_r == edadp_pkg::OP_XWR_REG));
  wire np_fin  = bus_fin & ~pe_r;
  wire strb_end = ce & strb_lo_r & pins.rd_n & pins.wr_n; // strobe released this clock

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_nonpage_len: assert property (np_fin && st_r == 3'h0 |-> bcyc_r == 6'h04)
    else $error("nonpage access not four clocks");
  a_internal_one: assert property (take && !is_bus |=> op_done)
    else $error("internal operation not one clock");
  a_stretch_one: assert property (np_fin && st_r == 3'h1 |-> bcyc_r == 6'h08)
    else $error("stretch one access not eight clocks");
  a_strobe_three: assert property (strb_end && !pe_r && st_r == 3'h3 |-> swid_r == 6'h0c)
    else $error("stretch three strobe not twelve clocks");
  a_four_page: assert property (bus_fin && pe_r && ps_r == 2'h2 && st_r == 3'h0
                                |-> bcyc_r == (hit_r ? 6'h04 : 6'h08))
    else $error("four-cycle page mode length wrong");
  a_two_page: assert property (bus_fin && pe_r && ps_r == 2'h1 && st_r == 3'h0
                               |-> bcyc_r == (hit_r ? 6'h02 : 6'h04))
    else $error("two-cycle page mode length wrong");
  a_one_page: assert property (bus_fin && pe_r && ps_r == 2'h0 && st_r == 3'h1
                               |-> bcyc_r == 6'h07)
    else $error("one-cycle page mode not seven clocks");
  a_stretch_four: assert property (np_fin && st_r == 3'h4 |-> bcyc_r == 6'h20)
    else $error("stretch four access not thirty-two clocks");
  a_strobe_seven: assert property (strb_end && !pe_r && st_r == 3'h7 |-> swid_r == 6'h1c)
    else $error("stretch seven strobe not twenty-eight clocks");
  a_mode2_len: assert property (bus_fin && pe_r && ps_r == 2'h3 && st_r == 3'h0
                                |-> bcyc_r == 6'h04)
    else $error("page mode 2 access not four clocks");
  a_step_up: assert property (op_done && q_step && !sel && !ctrl_r[6] && ce
                              |=> ptr0_r == $past(ptr0_r) + 16'h0001)
    else $error("first pointer not incremented");
  a_toggle_sel: assert property (op_done && q_tog && ce |=> ctrl_r[0] != $past(ctrl_r[0]))
    else $error("select not toggled");
  a_done_soon: assert property (take_bus && ce |-> ##[2:60] op_done)
    else $error("access did not finish");

  c_page_hit: cover property (bus_fin && pe_r && hit_r && ps_r != 2'h0);
  c_page_miss: cover property (bus_fin && pe_r && !hit_r);
  c_auto_both: cover property (op_done && q_step && q_tog);
  c_back_to_back: cover property (bus_fin ##2 bus_fin);

endmodule // edadp_ctrl

`default_nettype wire

// *** common/edadp_pkg.sv ***
package edadp_pkg;

  // special-function-space addresses of the pointer registers
  localparam logic [7:0] SFR_P0_LO = 8'h82;
  localparam logic [7:0] SFR_P0_HI = 8'h83;
  localparam logic [7:0] SFR_P1_LO = 8'h84;
  localparam logic [7:0] SFR_P1_HI = 8'h85;
  localparam logic [7:0] SFR_CTRL  = 8'h86;

  // pointer control field positions
  localparam int SEL_BIT  = 0;
  localparam int STEP_BIT = 4;
  localparam int TOG_BIT  = 5;
  localparam int DIR0_BIT = 6;
  localparam int DIR1_BIT = 7;

  // reset values and writable bits
  localparam logic [7:0]  CTRL_MASK = 8'hf1;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;

  // page select encodings
  localparam logic [1:0] PG_ONE   = 2'h0;
  localparam logic [1:0] PG_TWO   = 2'h1;
  localparam logic [1:0] PG_FOUR  = 2'h2;
  localparam logic [1:0] PG_MODE2 = 2'h3;

  // cycle counts, in system clocks
  localparam int         CNT_W       = 6;
  localparam logic [5:0] MISS_ONE    = 6'h02;
  localparam logic [5:0] MISS_TWO    = 6'h02;
  localparam logic [5:0] MISS_FOUR   = 6'h04;
  localparam logic [5:0] SETUP_STD   = 6'h01;
  localparam logic [5:0] STROBE_STD  = 6'h02;
  localparam logic [5:0] HOLD_STD    = 6'h01;
  localparam logic [5:0] SETUP_TWO   = 6'h01;
  localparam logic [5:0] STROBE_TWO  = 6'h01;
  localparam logic [5:0] HOLD_TWO    = 6'h00;
  localparam logic [5:0] SETUP_ONE   = 6'h00;
  localparam logic [5:0] STROBE_ONE  = 6'h01;
  localparam logic [5:0] HOLD_ONE    = 6'h00;
  localparam logic [5:0] XSETUP_LO   = 6'h01;
  localparam logic [5:0] XSETUP_HI   = 6'h09;
  localparam logic [5:0] XHOLD_LO    = 6'h01;
  localparam logic [5:0] XHOLD_HI    = 6'h05;
  localparam logic [5:0] XSTROBE_1ST = 6'h02;
  localparam logic [2:0] STRETCH_HI  = 3'h4;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_XRD_PTR = 3'h1,
    OP_XWR_PTR = 3'h2,
    OP_XRD_REG = 3'h3,
    OP_XWR_REG = 3'h4,
    OP_CODE_RD = 3'h5,
    OP_STEP    = 3'h6,
    OP_LOAD    = 3'h7
  } edadp_op_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } edadp_sfr_req_t;

  typedef struct packed {
    logic        valid;
    edadp_op_t   op;
    logic [7:0]  reg_low;
    logic [7:0]  p2_latch;
    logic [7:0]  wdata;
    logic [15:0] load_val;
  } edadp_op_req_t;

  typedef struct packed {
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] p0_out;
    logic       p0_oe;
    logic [7:0] p2_out;
    logic       p2_oe;
  } edadp_pins_t;

endpackage

// *** bench/edadp_xmem_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module edadp_xmem_model (
  input  wire logic                   clk,
  input  wire edadp_pkg::edadp_pins_t pins,
  input  wire logic                   mode2,
  output logic [7:0]                  p0_in,
  output logic [7:0]                  p2_in,
  output logic [15:0]                 last_addr
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk_r = 8'h5a;

  // latch address in the address phase, store data while write strobe low
  always_ff @(posedge clk)
  begin
    junk_r <= ~junk_r;  // released lines never hold the last value
    if (pins.ale)
      last_addr <= {pins.p2_out, pins.p0_out};
    if (!pins.wr_n)
      mem[last_addr] <= mode2 ? pins.p2_out : pins.p0_out;
  end

  // read data only while read strobe low, on the port carrying data
  assign p0_in = (!pins.rd_n && !mode2) ? mem[last_addr] : junk_r;
  assign p2_in = (!pins.rd_n && mode2) ? mem[last_addr] : junk_r;
endmodule // edadp_xmem_model

`default_nettype wire

// *** bench/edadp_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module edadp_tb_top;
  logic                      clk;
  logic                      rst;
  logic                      ce;
  logic                      page_enable;
  logic [1:0]                page_select;
  logic [2:0]                stretch_select;
  logic [7:0]                code_page_msb;
  logic [7:0]                p0_in;
  logic [7:0]                p2_in;
  logic [7:0]                sfr_rdata;
  logic [7:0]                xdata_rd;
  logic                      op_ready;
  logic                      op_done;
  logic                      mode2;
  logic [15:0]               code_addr;
  logic [15:0]               last_addr;
  edadp_pkg::edadp_sfr_req_t sfr_req;
  edadp_pkg::edadp_op_req_t  op_req;
  edadp_pkg::edadp_pins_t    pins;
  int                        num_errors = 0;
  int                        checks = 0;
  int                        n_cyc;
  int                        n_str;

  assign mode2 = page_enable && (page_select == edadp_pkg::PG_MODE2);

  edadp_ctrl dut (.clk(clk), .rst(rst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .op_req(op_req), .op_ready(op_ready), .op_done(op_done), .xdata_rd(xdata_rd),
    .code_addr(code_addr), .page_enable(page_enable), .page_select(page_select),
    .stretch_select(stretch_select), .code_page_msb(code_page_msb), .p0_in(p0_in),
    .p2_in(p2_in), .pins(pins));

  edadp_xmem_model mem_model (.clk(clk), .pins(pins), .mode2(mode2), .p0_in(p0_in),
    .p2_in(p2_in), .last_addr(last_addr));

  // free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    sfr_req.wr = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    sfr_req.rd = 1'b0;
    check({8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  // one operation; counts cycles to done and strobe-low cycles
  task automatic do_op(input edadp_pkg::edadp_op_t op, input logic [7:0] rl,
                       input logic [7:0] p2l, input logic [7:0] wd, input logic [15:0] ld);
    @(negedge clk);
    op_req = '{1'b1, op, rl, p2l, wd, ld};
    n_cyc = 0;
    n_str = 0;
    @(negedge clk);
    op_req.valid = 1'b0;
    repeat (200)
    begin
      n_cyc++;
      if (!pins.rd_n || !pins.wr_n)
        n_str++;
      if (op_done === 1'b1)
        break;
      @(negedge clk);
    end
    check({15'h0000, op_done}, 16'h0001);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 5; i++)
      sfr_rd(8'h82 + 8'(i), 8'h00);
    for (int i = 0; i < 4; i++)
      sfr_wr(8'h82 + 8'(i), 8'h11 * 8'(i + 1));
    sfr_wr(8'h86, 8'hfe);
    sfr_wr(8'h87, 8'h99);
    for (int i = 0; i < 4; i++)
      sfr_rd(8'h82 + 8'(i), 8'h11 * 8'(i + 1));
    sfr_rd(8'h86, 8'hf0);
    sfr_rd(8'h87, 8'h00);
  endtask

  // every bus mode, stretch value and hit or miss
  task automatic t_timing();
    int su;
    int st;
    int ho;
    int mi;
    sfr_wr(8'h86, 8'h00);
    sfr_wr(8'h83, 8'h12);
    for (int m = 0; m < 5; m++)
      for (int s = 0; s < 8; s++)
        for (int h = 0; h < 2; h++)
        begin
          page_enable = (m != 4);
          page_select = m[1:0];
          stretch_select = s[2:0];
          code_page_msb = h ? 8'h12 : 8'h34;
          do_op(edadp_pkg::OP_XWR_PTR, 8'h00, 8'h00, 8'ha5, 16'h0000);
          su = (m == 0) ? 0 : 1;
          st = (m < 2) ? 1 : 2;
          ho = (m < 2) ? 0 : 1;
          mi = (m == 0) ? 2 : (h == 0 && m == 1) ? 2 : (h == 0 && m == 2) ? 4 : 0;
          su += (s > 0) + 8 * (s > 3);
          st += (s > 0) ? 4 * s - 2 : 0;
          ho += (s > 0) + 4 * (s > 3);
          check(16'(n_cyc), 16'(su + st + ho + mi + 1));
          check(16'(n_str), 16'(st));
        end
  endtask

  task automatic t_data();
    page_enable = 1'b0;
    stretch_select = 3'h0;
    do_op(edadp_pkg::OP_XWR_PTR, 8'h00, 8'h00, 8'h5a, 16'h0000);
    do_op(edadp_pkg::OP_XRD_PTR, 8'h00, 8'h00, 8'h00, 16'h0000);
    check({8'h00, xdata_rd}, 16'h005a);
    check(last_addr, 16'h1211);
    do_op(edadp_pkg::OP_XWR_REG, 8'h34, 8'h56, 8'hc3, 16'h0000);
    check(last_addr, 16'h5634);
    do_op(edadp_pkg::OP_XRD_REG, 8'h34, 8'h56, 8'h00, 16'h0000);
    check({8'h00, xdata_rd}, 16'h00c3);
    page_enable = 1'b1;
    page_select = edadp_pkg::PG_MODE2;
    do_op(edadp_pkg::OP_XWR_REG, 8'h77, 8'h56, 8'h3c, 16'h0000);
    do_op(edadp_pkg::OP_XRD_REG, 8'h77, 8'h56, 8'h00, 16'h0000);
    check({8'h00, xdata_rd}, 16'h003c);
    check(last_addr, 16'h5677);
    page_enable = 1'b0;
  endtask

  task automatic t_ptr();
    sfr_wr(8'h82, 8'h00);
    sfr_wr(8'h83, 8'h10);
    sfr_wr(8'h84, 8'h00);
    sfr_wr(8'h85, 8'h20);
    sfr_wr(8'h86, 8'hb0);
    do_op(edadp_pkg::OP_XWR_PTR, 8'h00, 8'h00, 8'h01, 16'h0000);
    check(last_addr, 16'h1000);
    do_op(edadp_pkg::OP_XWR_PTR, 8'h00, 8'h00, 8'h02, 16'h0000);
    check(last_addr, 16'h2000);
    sfr_rd(8'h82, 8'h01);
    sfr_rd(8'h84, 8'hff);
    sfr_rd(8'h85, 8'h1f);
    sfr_rd(8'h86, 8'hb0);
    do_op(edadp_pkg::OP_STEP, 8'h00, 8'h00, 8'h00, 16'h0000);
    sfr_rd(8'h82, 8'h02);
    sfr_rd(8'h86, 8'hb1);
    do_op(edadp_pkg::OP_LOAD, 8'h00, 8'h00, 8'h00, 16'habcd);
    sfr_rd(8'h85, 8'hab);
    sfr_rd(8'h86, 8'hb0);
    do_op(edadp_pkg::OP_CODE_RD, 8'h00, 8'h00, 8'h00, 16'h0000);
    check(code_addr, 16'h1002);
    sfr_rd(8'h82, 8'h03);
    do_op(edadp_pkg::OP_XWR_REG, 8'h01, 8'h02, 8'h00, 16'h0000);
    sfr_rd(8'h86, 8'hb1);
    sfr_wr(8'h86, 8'h81);
    do_op(edadp_pkg::OP_STEP, 8'h00, 8'h00, 8'h00, 16'h0000);
    sfr_rd(8'h84, 8'hcc);
    sfr_rd(8'h86, 8'h81);
  endtask

  // main sequence: reset for eight clocks, then each scenario
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    page_enable = 1'b0;
    page_select = 2'h0;
    stretch_select = 3'h0;
    code_page_msb = 8'h00;
    sfr_req = '0;
    op_req = '0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_timing();
    t_data();
    t_ptr();
    complete_run();
  end

  // watchdog, well beyond the few thousand cycles the run needs
  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule // edadp_tb_top

`default_nettype wire
